// ==== design/rxp_map.vh ====
// register offsets, field positions and reset values of the receive output port
`ifndef RXP_MAP_VH
`define RXP_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RXP_OFF_CTRL      8'h00
`define RXP_OFF_STATE     8'h04
`define RXP_OFF_INT_STAT  8'h08
`define RXP_OFF_INT_MASK  8'h0C

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define RXP_CTRL_SRC_SEL  0
`define RXP_CTRL_RATE_SEL 1
`define RXP_CTRL_BYPASS   2
`define RXP_CTRL_REF_HALF 3
`define RXP_CTRL_W        4
`define RXP_CTRL_RST      4'h0

// ----------------------------------------------------------------
// interrupt fields
// ----------------------------------------------------------------
`define RXP_INT_UPD       0
`define RXP_INT_COMMA     1
`define RXP_INT_OVR       2
`define RXP_INT_W         3
`define RXP_INT_RST       3'h0

// ----------------------------------------------------------------
// status table and state register layout
// ----------------------------------------------------------------
`define RXP_STAT_TABLE    24'hFAC688
`define RXP_ST_CHAR_LSB   0
`define RXP_ST_STAT_LSB   8
`define RXP_ST_IFCLK      11
`define RXP_ST_PENDING    12
`define RXP_ST_REF        13
`define RXP_ST_REC        14

`endif

// ==== design/rxp_sync2.v ====
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none

module rxp_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // level in and out
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule // rxp_sync2

`default_nettype wire

// ==== design/rxp_top.v ====
// receive parallel output port: characters, status and interface clock
// Functional notes
// - character and status outputs change only on interface clock update edges.
// - a written control bit picks recovered or reference clock as source.
// - full rate: true and complement clocks at character rate, data on rise.
// - half rate: data changes on both clock edges; host captures on both.
// - decoder bypassed: two low undecoded character bits on status lines 1:0.
// - decoder bypassed: status line 2 high while presented character is comma.
// - decoder enabled: all three status lines report character status.
// - interface clock runs continuously at half or full character rate.
// - reference source: clock is delayed copy or divided form of reference.
// - full-rate reference, or recovered source: rate follows rate select.
// - half-rate reference selected: clock follows reference, rate select ignored.
// - reset asynchronously forces all state and control latches to initial values.
// - reset leaves the boundary scan controller alone; none lives here.
// - half-rate reference: outputs presented on both reference edges.
// - source select zero picks the recovered clock.
`timescale 1ns/1ns
`default_nettype none
`include "rxp_map.vh"

module rxp_top #(
  parameter [23:0] STAT_TABLE = `RXP_STAT_TABLE
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // clock pins
  input  wire        rec_clk_pin,
  input  wire        ref_clock_in,
  // characters from the decoder side, pclk domain
  input  wire        char_valid,
  input  wire [7:0]  dec_char,
  input  wire [2:0]  dec_status_kind,
  input  wire [9:0]  raw_char,
  input  wire        raw_comma,
  // parallel output port
  output reg  [7:0]  recv_char_out,
  output reg  [2:0]  recv_status_out,
  output reg         recv_iface_clk,
  output reg         recv_iface_clk_n,
  // interrupt
  output wire        irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // register state
  reg  [`RXP_CTRL_W-1:0] ctrl_r;
  reg  [`RXP_INT_W-1:0]  int_stat_r;
  reg  [`RXP_INT_W-1:0]  int_mask_r;
  reg  [7:0]             stage_char_r;
  reg  [2:0]             stage_stat_r;
  reg                    stage_full_r;
  reg                    src_d_r;

  // combinational next values
  reg  [`RXP_INT_W-1:0]  int_stat_nxt;
  reg                    clk_nxt;
  reg  [31:0]            rdata_nxt;
  reg                    addr_ok;

  // synchronised pins and mode decode
  wire [1:0]             pins_s;
  wire                   rec_s;
  wire                   ref_s;
  wire                   src_sel;
  wire                   rate_half;
  wire                   bypass;
  wire                   ref_half;
  wire                   ref_follow;
  wire                   full_rate;
  wire                   mode_copy;
  wire                   mode_toggle;

  // source edges
  wire                   src_s;
  wire                   src_rise;
  wire                   src_fall;
  wire                   upd;

  // capture path
  wire [2:0]             stat_entry [0:7];
  wire [2:0]             dec_stat;
  wire [7:0]             cap_char;
  wire [2:0]             cap_stat;
  wire [`RXP_INT_W-1:0]  int_evt;

  // bus decode
  wire                   setup;
  wire                   wr_en;
  wire                   wr_ctrl;
  wire                   wr_int_stat;
  wire                   wr_int_mask;
  wire [31:0]            state_word;

  // ----------------------------------------------------------------
  // clock pin synchronisation
  // ----------------------------------------------------------------
  rxp_sync2 #(
    .W       (2)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    ({rec_clk_pin, ref_clock_in}),
    .q_out   (pins_s)
  );

  assign rec_s = pins_s[1];
  assign ref_s = pins_s[0];

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  assign src_sel   = ctrl_r[`RXP_CTRL_SRC_SEL];
  assign rate_half = ctrl_r[`RXP_CTRL_RATE_SEL];
  assign bypass    = ctrl_r[`RXP_CTRL_BYPASS];
  assign ref_half  = ctrl_r[`RXP_CTRL_REF_HALF];

  // zero selects the recovered clock
  assign src_s = src_sel ? ref_s : rec_s;

  // half-rate reference as source: follow it, ignore rate select
  assign ref_follow = ref_half & src_sel;

  // otherwise rate select decides
  assign full_rate = ~rate_half;

  // copy the source, or toggle once per source rise
  assign mode_copy   = ref_follow | full_rate;
  assign mode_toggle = ~mode_copy;

  // ----------------------------------------------------------------
  // source edge detection
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_d_r <= 1'b0;
    end else begin
      src_d_r <= src_s;
    end
  end

  assign src_rise = src_s & ~src_d_r;
  assign src_fall = ~src_s & src_d_r;

  // update on both reference edges when following a half-rate reference
  assign upd = ref_follow ? (src_rise | src_fall) : src_rise;

  // ----------------------------------------------------------------
  // interface clock generation
  // ----------------------------------------------------------------
  always @* begin
    if (mode_copy) begin
      clk_nxt = src_s;
    end else if (mode_toggle && src_rise) begin
      clk_nxt = ~recv_iface_clk;
    end else begin
      clk_nxt = recv_iface_clk;
    end
  end

  // runs continuously from the source clock regardless of data activity
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recv_iface_clk   <= 1'b0;
      recv_iface_clk_n <= 1'b1;
    end else begin
      recv_iface_clk   <= clk_nxt;
      recv_iface_clk_n <= ~clk_nxt;
    end
  end

  // ----------------------------------------------------------------
  // character capture and status formatting
  // ----------------------------------------------------------------
  // one table entry per decoded status kind
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat
      assign stat_entry[gi] = STAT_TABLE[gi*3 +: 3];
    end
  endgenerate

  assign dec_stat = stat_entry[dec_status_kind];

  assign cap_char = bypass ? raw_char[9:2] : dec_char;

  // bypass: comma flag and low raw bits; else decoded status
  assign cap_stat = bypass ? {raw_comma, raw_char[1:0]} : dec_stat;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_char_r <= 8'h00;
      stage_stat_r <= 3'h0;
    end else if (char_valid) begin
      stage_char_r <= cap_char;
      stage_stat_r <= cap_stat;
    end
  end

  // a new character keeps the stage full even on an update edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_full_r <= 1'b0;
    end else if (char_valid) begin
      stage_full_r <= 1'b1;
    end else if (upd) begin
      stage_full_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recv_char_out   <= 8'h00;
      recv_status_out <= 3'h0;
    end else if (upd && stage_full_r) begin
      recv_char_out   <= stage_char_r;
      recv_status_out <= stage_stat_r;
    end
  end

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  assign int_evt[`RXP_INT_UPD]   = upd & stage_full_r;
  assign int_evt[`RXP_INT_COMMA] = upd & stage_full_r & bypass & stage_stat_r[2];
  assign int_evt[`RXP_INT_OVR]   = char_valid & stage_full_r & ~upd;

  // write one clears, a new event in the same cycle wins
  always @* begin
    int_stat_nxt = int_stat_r;
    if (wr_int_stat) begin
      int_stat_nxt = int_stat_r & ~pwdata[`RXP_INT_W-1:0];
    end
    int_stat_nxt = int_stat_nxt | int_evt;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= `RXP_INT_RST;
    end else begin
      int_stat_r <= int_stat_nxt;
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  always @* begin
    case (paddr)
      `RXP_OFF_CTRL:     addr_ok = 1'b1;
      `RXP_OFF_STATE:    addr_ok = 1'b1;
      `RXP_OFF_INT_STAT: addr_ok = 1'b1;
      `RXP_OFF_INT_MASK: addr_ok = 1'b1;
      default:           addr_ok = 1'b0;
    endcase
  end

  assign setup       = psel & ~penable;
  assign wr_en       = psel & penable & pwrite & addr_ok;
  assign wr_ctrl     = wr_en & (paddr == `RXP_OFF_CTRL);
  assign wr_int_stat = wr_en & (paddr == `RXP_OFF_INT_STAT);
  assign wr_int_mask = wr_en & (paddr == `RXP_OFF_INT_MASK);

  // ----------------------------------------------------------------
  // apb register writes
  // ----------------------------------------------------------------
  // reset touches only this port's latches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `RXP_CTRL_RST;
      int_mask_r <= `RXP_INT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[`RXP_CTRL_W-1:0];
      end
      if (wr_int_mask) begin
        int_mask_r <= pwdata[`RXP_INT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------
  // state word fields
  assign state_word[`RXP_ST_CHAR_LSB +: 8] = recv_char_out;
  assign state_word[`RXP_ST_STAT_LSB +: 3] = recv_status_out;
  assign state_word[`RXP_ST_IFCLK]         = recv_iface_clk;
  assign state_word[`RXP_ST_PENDING]       = stage_full_r;
  assign state_word[`RXP_ST_REF]           = ref_s;
  assign state_word[`RXP_ST_REC]           = rec_s;
  assign state_word[31:`RXP_ST_REC+1]      = 17'h00000;

  always @* begin
    case (paddr)
      `RXP_OFF_CTRL:     rdata_nxt = {28'h0000000, ctrl_r};
      `RXP_OFF_STATE:    rdata_nxt = state_word;
      `RXP_OFF_INT_STAT: rdata_nxt = {29'h0, int_stat_r};
      `RXP_OFF_INT_MASK: rdata_nxt = {29'h0, int_mask_r};
      default:           rdata_nxt = 32'h00000000;
    endcase
  end

  // read data captured in setup, steady through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rdata_nxt;
    end
  end

  // unmapped offsets answer with an error in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~addr_ok;
    end
  end

  assign pready = 1'b1;

endmodule // rxp_top

`default_nettype wire

// ==== test/rxp_top_monitor.sv ====
// assertions on the receive output port pins
`timescale 1ns/1ns
`default_nettype none
module rxp_top_monitor (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // output port
  input wire logic [7:0]  recv_char_out,
  input wire logic [2:0]  recv_status_out,
  input wire logic        recv_iface_clk,
  input wire logic        recv_iface_clk_n,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_hi_a: assert property (psel && penable |-> pready)
    else $error("pready low");
  clk_pair_a: assert property (recv_iface_clk_n == !recv_iface_clk)
    else $error("clocks not complementary");
  char_edge_a: assert property ($changed(recv_char_out) |-> $changed(recv_iface_clk))
    else $error("char moved off clock edge");
  stat_edge_a: assert property ($changed(recv_status_out) |-> $changed(recv_iface_clk))
    else $error("status moved off clock edge");
  bad_addr_a: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("no error on unmapped");
  bad_read_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_hi_a: assert property (psel && penable && !pwrite && paddr == 8'h00 |-> prdata[31:4] == 28'h0)
    else $error("control upper bits set");
  rst_out_a: assert property (disable iff (1'b0) !presetn |-> recv_char_out == 8'h00 && !irq)
    else $error("outputs not reset");
endmodule // rxp_top_monitor
bind rxp_top rxp_top_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .recv_char_out(recv_char_out),
  .recv_status_out(recv_status_out), .recv_iface_clk(recv_iface_clk),
  .recv_iface_clk_n(recv_iface_clk_n), .irq(irq));
`default_nettype wire

// ==== test/rxp_host_cap.sv ====
// partner model: host logic capturing port characters
`timescale 1ns/1ns
`default_nettype none
module rxp_host_cap (
  input  wire logic       pclk,
  input  wire logic       both_edges,
  input  wire logic       recv_iface_clk,
  input  wire logic [7:0] recv_char_out,
  input  wire logic [2:0] recv_status_out,
  output var  logic [7:0] cap_char,
  output var  logic [2:0] cap_stat,
  output var  int         cap_cnt
);
  logic clk_q = 1'b0;
  initial cap_cnt = 0;
  // take data on the rise, and on the fall at half rate
  always @(posedge pclk) begin
    clk_q <= recv_iface_clk;
    if (clk_q !== recv_iface_clk && (recv_iface_clk || both_edges)) begin
      cap_char <= recv_char_out;
      cap_stat <= recv_status_out;
      cap_cnt <= cap_cnt + 1;
    end
  end
endmodule // rxp_host_cap
`default_nettype wire

// ==== test/rxp_top_tb.sv ====
// self-checking bench for the receive output port
`timescale 1ns/1ns
`default_nettype none
module rxp_top_tb;
  localparam [23:0] TBL = 24'h053977;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        rec_pin = 1'b0;
  logic        ref_pin = 1'b0;
  logic        cv = 1'b0;
  logic [7:0]  dch = 8'h00;
  logic [2:0]  kind = 3'h0;
  logic [9:0]  raw = 10'h000;
  logic        both = 1'b0;
  logic [31:0] rd;
  logic        err;
  wire         pready, pslverr, irq, clk_p, clk_n;
  wire  [31:0] prdata;
  wire  [7:0]  char_o, cap_char;
  wire  [2:0]  stat_o, cap_stat;
  int          cap_cnt, n0;
  int          fail_count = 0;
  int          checks = 0;

  rxp_top #(.STAT_TABLE(TBL)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rec_clk_pin(rec_pin), .ref_clock_in(ref_pin), .char_valid(cv), .dec_char(dch), .dec_status_kind(kind),
    .raw_char(raw), .raw_comma(raw[5]), .recv_char_out(char_o), .recv_status_out(stat_o),
    .recv_iface_clk(clk_p), .recv_iface_clk_n(clk_n), .irq(irq));
  rxp_host_cap host (.pclk(pclk), .both_edges(both), .recv_iface_clk(clk_p), .recv_char_out(char_o),
    .recv_status_out(stat_o), .cap_char(cap_char), .cap_stat(cap_stat), .cap_cnt(cap_cnt));

  initial forever #10 pclk = ~pclk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("mismatches %0d comparisons %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // stage one character, then one source clock pulse
  task send(input logic [7:0] c, input logic [2:0] k, input logic [9:0] r, input logic use_ref);
    n0 = cap_cnt;
    dch <= c;
    kind <= k;
    raw <= r;
    cv <= 1'b1;
    @(posedge pclk);
    cv <= 1'b0;
    repeat (2) begin
      if (use_ref)
        ref_pin <= ~ref_pin;
      else
        rec_pin <= ~rec_pin;
      repeat (6)
        @(posedge pclk);
    end
  endtask

  task t_reset;
    apb(1'b1, 8'h00, 32'hF);
    presetn <= 1'b0;
    repeat (3)
      @(posedge pclk);
    chk(clk_n, 32'h1);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 8'h44, 32'hF);
    chk(err, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
  endtask

  task t_full;
    apb(1'b1, 8'h00, 32'h0);
    for (int k = 0; k < 8; k++) begin
      send({5'h14, k[2:0]}, k[2:0], 10'h0, 1'b0);
      chk(cap_char, {5'h14, k[2:0]});
      chk(cap_stat, TBL[3*k +: 3]);
      chk(cap_cnt - n0, 32'h1);
    end
  endtask

  task t_bypass;
    logic [9:0] r;
    apb(1'b1, 8'h00, 32'h4);
    for (int i = 0; i < 4; i++) begin
      r = {i[1:0], 2'h1, i[1:0], 2'h2, i[1:0]};
      send(8'h00, 3'h0, r, 1'b0);
      chk(cap_char, r[9:2]);
      chk(cap_stat, {r[5], r[1:0]});
    end
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[2:0], 32'h3);
  endtask

  task t_half;
    both <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h00, (i == 0) ? 32'h2 : 32'hA);
      send({7'h1E, i[0]}, 3'h0, 10'h0, 1'b0);
      chk(cap_char, {7'h1E, i[0]});
      chk(cap_cnt - n0, 32'h1);
    end
  endtask

  task t_ref;
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 8'h00, (m == 0) ? 32'h1 : 32'h7 + 32'(2 * m));
      both <= (m != 0);
      send({6'h30, m[1:0]}, 3'h0, 10'h0, 1'b1);
      chk(cap_char, {6'h30, m[1:0]});
      chk(cap_cnt - n0, (m == 0) ? 32'h1 : 32'h2);
      chk(clk_p, ref_pin);
    end
  endtask

  task t_irq;
    apb(1'b1, 8'h00, 32'h0);
    both <= 1'b0;
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h08, 32'h7);
    send(8'h11, 3'h1, 10'h0, 1'b0);
    chk(irq, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[0], 32'h1);
    apb(1'b1, 8'h0C, 32'h1);
    chk(irq, 32'h1);
    apb(1'b1, 8'h08, 32'h1);
    chk(irq, 32'h0);
    cv <= 1'b1;
    repeat (2)
      @(posedge pclk);
    cv <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[2:0], 32'h4);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[7:0], 32'h11);
    chk(rd[12], 32'h1);
  endtask

  initial begin
    repeat (20000)
      @(posedge pclk);
    fail_count++;
    stop_test;
  end

  initial begin
    presetn <= 1'b0;
    repeat (3)
      @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_full;
    t_bypass;
    t_half;
    t_ref;
    t_irq;
    stop_test;
  end
endmodule // rxp_top_tb
`default_nettype wire
